//--- src/mrb_consts.vh
`ifndef MRB_CONSTS_VH
`define MRB_CONSTS_VH

// Register byte offsets
`define MRB_OFS_CMD      8'h00
`define MRB_OFS_OPND     8'h04
`define MRB_OFS_WORK     8'h08
`define MRB_OFS_STATUS   8'h0C
`define MRB_OFS_IRQCTL   8'h10
`define MRB_OFS_PC       8'h14
`define MRB_OFS_STACK    8'h18
`define MRB_OFS_MEMADDR  8'h1C
`define MRB_OFS_MEMDATA  8'h20
`define MRB_OFS_STATE    8'h24

// Status flag positions
`define MRB_FLG_C        0
`define MRB_FLG_AC       1
`define MRB_FLG_Z        2
`define MRB_FLG_OV       3
`define MRB_FLG_PD       4
`define MRB_FLG_TO       5
`define MRB_FLG_W        6

// Operand register fields
`define MRB_OPND_ADDR_LSB 0
`define MRB_OPND_IMM_LSB  8
`define MRB_OPND_JMP_LSB  16

// Interrupt control bit, state register bits
`define MRB_IRQ_GIE      0
`define MRB_STATE_BUSY   0
`define MRB_STATE_SLEEP  1
`define MRB_STATE_WAKE   0

// BCD constants
`define MRB_BCD_LIMIT    4'h9
`define MRB_BCD_ADJ      5'h06

// Reset values
`define MRB_RST_STATUS   7'h00
`define MRB_RST_WORK     8'h00

// Operation codes
`define MRB_OP_INV_W     5'h01
`define MRB_OP_BCD       5'h02
`define MRB_OP_DEC_M     5'h03
`define MRB_OP_DEC_W     5'h04
`define MRB_OP_INC_M     5'h05
`define MRB_OP_INC_W     5'h06
`define MRB_OP_HALT      5'h07
`define MRB_OP_JMP       5'h08
`define MRB_OP_MOV_IMM   5'h09
`define MRB_OP_MOV_W2M   5'h0A
`define MRB_OP_OR_W      5'h0B
`define MRB_OP_OR_IMM    5'h0C
`define MRB_OP_OR_M      5'h0D
`define MRB_OP_RET       5'h0E
`define MRB_OP_RET_IMM   5'h0F
`define MRB_OP_INTERRUPT_EXIT      5'h10
`define MRB_OP_RL        5'h11
`define MRB_OP_RL_W      5'h12
`define MRB_OP_RLC       5'h13
`define MRB_OP_RLC_W     5'h14
`define MRB_OP_RR        5'h15
`define MRB_OP_RR_W      5'h16
`define MRB_OP_RRC       5'h17
`define MRB_OP_RRC_W     5'h18
`define MRB_OP_SBC       5'h19
`define MRB_OP_SBC_M     5'h1A

`endif

//--- src/mrb_exec.v
// Implementation choices: the register addresses and the AHB-Lite interface to the registers.
`include "mrb_consts.vh"
`default_nettype none

module mrb_exec #(
    parameter PC_W     = 12,
    parameter STACK_N  = 4,
    parameter MEM_N    = 256
) (
    // AHB-Lite slave
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    // Core side
    output wire        sys_clk_run,
    output wire        global_irq_enable,
    output reg         wdt_clear
);

    localparam ST_RUN  = 3'b001;
    localparam ST_WAIT = 3'b010;
    localparam ST_HALT = 3'b100;
    reg  [2:0]      state;
    reg  [7:0]      work;
    reg  [6:0]      flags;
    reg  [7:0]      irq_control_reg;
    reg  [PC_W-1:0] pc;
    reg  [31:0]     opnd;
    reg  [7:0]      mem_addr;
    reg  [1:0]      sp;
    reg  [PC_W-1:0] stack [0:STACK_N-1];
    reg  [7:0]      dmem  [0:MEM_N-1];
    // Bus phase tracking
    reg             dp_write;
    reg             dp_read;
    reg             rd_wait;
    reg  [7:0]      dp_addr;

    wire addr_take = hsel & hready & htrans[1];
    wire wr_cmd    = dp_write & (dp_addr == `MRB_OFS_CMD);
    wire [4:0] op  = hwdata[4:0];
    wire issue     = wr_cmd & state[0];
    wire [7:0]      m_addr = opnd[`MRB_OPND_ADDR_LSB +: 8];
    wire [7:0]      imm    = opnd[`MRB_OPND_IMM_LSB +: 8];
    wire [PC_W-1:0] jaddr  = opnd[`MRB_OPND_JMP_LSB +: PC_W];
    wire [7:0]      m      = dmem[m_addr];
    wire            c_in   = flags[`MRB_FLG_C];
    assign hreadyout         = ~rd_wait;
    assign hresp             = 1'b0;
    assign sys_clk_run       = ~state[2];
    assign global_irq_enable = irq_control_reg[`MRB_IRQ_GIE];

    function zero8;
        input [7:0] v;
        begin
            zero8 = (v == 8'h00);
        end
    endfunction

    // Execution datapath
    reg  [7:0]      next_work;
    reg  [7:0]      next_mem;
    reg             mem_we;
    reg  [6:0]      next_flags;
    reg  [PC_W-1:0] next_pc;
    reg             pop;
    reg             set_gie;
    reg             go_halt;
    reg             two_cycle;
    reg  [4:0]      lo_sum;
    reg  [4:0]      hi_sum;
    reg  [8:0]      sub_sum;
    reg  [4:0]      sub_lo;
    reg  [7:0]      res;

    always @* begin
        next_work  = work;
        next_mem   = m;
        mem_we     = 1'b0;
        next_flags = flags;
        next_pc    = pc + {{(PC_W-1){1'b0}}, 1'b1};
        pop        = 1'b0;
        set_gie    = 1'b0;
        go_halt    = 1'b0;
        two_cycle  = 1'b0;
        lo_sum     = 5'h00;
        hi_sum     = 5'h00;
        sub_sum    = 9'h000;
        sub_lo     = 5'h00;
        res        = 8'h00;
        case (op)
            `MRB_OP_INV_W: begin
                next_work = ~m;
                next_flags[`MRB_FLG_Z] = zero8(~m);
            end
            `MRB_OP_BCD: begin
                if (work[3:0] > `MRB_BCD_LIMIT || flags[`MRB_FLG_AC]) begin
                    lo_sum = {1'b0, work[3:0]} + `MRB_BCD_ADJ;
                end else begin
                    lo_sum = {1'b0, work[3:0]};
                end
                if (work[7:4] > `MRB_BCD_LIMIT || c_in) begin
                    hi_sum = {1'b0, work[7:4]} + `MRB_BCD_ADJ + {4'h0, lo_sum[4]};
                    next_flags[`MRB_FLG_C] = 1'b1;
                end else begin
                    hi_sum = {1'b0, work[7:4]} + {4'h0, lo_sum[4]};
                end
                next_mem = {hi_sum[3:0], lo_sum[3:0]};
                mem_we   = 1'b1;
            end
            `MRB_OP_DEC_M, `MRB_OP_DEC_W: begin
                res = m - 8'h01;
                next_flags[`MRB_FLG_Z] = zero8(res);
                if (op == `MRB_OP_DEC_M) begin
                    next_mem = res;
                    mem_we   = 1'b1;
                end else begin
                    next_work = res;
                end
            end
            `MRB_OP_INC_M, `MRB_OP_INC_W: begin
                res = m + 8'h01;
                next_flags[`MRB_FLG_Z] = zero8(res);
                if (op == `MRB_OP_INC_M) begin
                    next_mem = res;
                    mem_we   = 1'b1;
                end else begin
                    next_work = res;
                end
            end
            `MRB_OP_HALT: begin
                go_halt = 1'b1;
                next_flags[`MRB_FLG_PD] = 1'b1;
                next_flags[`MRB_FLG_TO] = 1'b0;
            end
            `MRB_OP_JMP: begin
                next_pc   = jaddr;
                two_cycle = 1'b1;
            end
            `MRB_OP_MOV_IMM: begin
                next_work = imm;
            end
            `MRB_OP_MOV_W2M: begin
                next_mem = work;
                mem_we   = 1'b1;
            end
            `MRB_OP_OR_W, `MRB_OP_OR_IMM, `MRB_OP_OR_M: begin
                res = work | ((op == `MRB_OP_OR_IMM) ? imm : m);
                next_flags[`MRB_FLG_Z] = zero8(res);
                if (op == `MRB_OP_OR_M) begin
                    next_mem = res;
                    mem_we   = 1'b1;
                end else begin
                    next_work = res;
                end
            end
            `MRB_OP_RET, `MRB_OP_RET_IMM, `MRB_OP_INTERRUPT_EXIT: begin
                pop       = 1'b1;
                next_pc   = stack[sp - 2'd1];
                two_cycle = 1'b1;
                if (op == `MRB_OP_RET_IMM)
                    next_work = imm;
                set_gie = (op == `MRB_OP_INTERRUPT_EXIT);
            end
            `MRB_OP_RL, `MRB_OP_RL_W: begin
                res = {m[6:0], m[7]};
                if (op == `MRB_OP_RL) begin
                    next_mem = res;
                    mem_we   = 1'b1;
                end else begin
                    next_work = res;
                end
            end
            `MRB_OP_RLC, `MRB_OP_RLC_W: begin
                res = {m[6:0], c_in};
                next_flags[`MRB_FLG_C] = m[7];
                if (op == `MRB_OP_RLC) begin
                    next_mem = res;
                    mem_we   = 1'b1;
                end else begin
                    next_work = res;
                end
            end
            `MRB_OP_RR, `MRB_OP_RR_W: begin
                res = {m[0], m[7:1]};
                if (op == `MRB_OP_RR) begin
                    next_mem = res;
                    mem_we   = 1'b1;
                end else begin
                    next_work = res;
                end
            end
            `MRB_OP_RRC, `MRB_OP_RRC_W: begin
                res = {c_in, m[7:1]};
                next_flags[`MRB_FLG_C] = m[0];
                if (op == `MRB_OP_RRC) begin
                    next_mem = res;
                    mem_we   = 1'b1;
                end else begin
                    next_work = res;
                end
            end
            `MRB_OP_SBC, `MRB_OP_SBC_M: begin
                sub_sum = {1'b0, work} + {1'b0, ~m} + {8'h00, c_in};
                sub_lo  = {1'b0, work[3:0]} + {1'b0, ~m[3:0]} + {4'h0, c_in};
                res     = sub_sum[7:0];
                next_flags[`MRB_FLG_C]  = sub_sum[8];
                next_flags[`MRB_FLG_AC] = sub_lo[4];
                next_flags[`MRB_FLG_Z]  = zero8(res);
                next_flags[`MRB_FLG_OV] = (work[7] == ~m[7]) & (res[7] != work[7]);
                if (op == `MRB_OP_SBC_M) begin
                    next_mem = res;
                    mem_we   = 1'b1;
                end else begin
                    next_work = res;
                end
            end
            // Unknown codes retire as a no-op that only steps the counter
            default: next_pc = pc + {{(PC_W-1){1'b0}}, 1'b1};
        endcase
    end

    // Bus read mux
    reg [31:0] rd_val;

    always @* begin
        rd_val = 32'h0000_0000;
        case (dp_addr)
            `MRB_OFS_OPND:    rd_val = opnd;
            `MRB_OFS_WORK:    rd_val = {24'h00_0000, work};
            `MRB_OFS_STATUS:  rd_val = {25'h000_0000, flags};
            `MRB_OFS_IRQCTL:  rd_val = {24'h00_0000, irq_control_reg};
            `MRB_OFS_PC:      rd_val = {{(32-PC_W){1'b0}}, pc};
            `MRB_OFS_STACK:   rd_val = {30'h0000_0000, sp};
            `MRB_OFS_MEMADDR: rd_val = {24'h00_0000, mem_addr};
            `MRB_OFS_MEMDATA: rd_val = {24'h00_0000, dmem[mem_addr]};
            `MRB_OFS_STATE:   rd_val = {30'h0000_0000, state[2], ~state[0]};
            default:          rd_val = 32'h0000_0000;
        endcase
    end

    // Bus phases; reads take one wait state so the value sees prior writes
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_read  <= 1'b0;
            rd_wait  <= 1'b0;
            dp_addr  <= 8'h00;
            hrdata   <= 32'h0000_0000;
        end else begin
            if (hready) begin
                dp_write <= addr_take & hwrite;
                dp_read  <= addr_take & ~hwrite;
                rd_wait  <= addr_take & ~hwrite;
                if (addr_take)
                    dp_addr <= {haddr[7:2], 2'b00};
            end else begin
                rd_wait <= 1'b0;
            end
            if (dp_read & rd_wait)
                hrdata <= rd_val;
        end
    end

    // Architectural state
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state           <= ST_RUN;
            work            <= `MRB_RST_WORK;
            flags           <= `MRB_RST_STATUS;
            irq_control_reg <= 8'h00;
            pc              <= {PC_W{1'b0}};
            opnd            <= 32'h0000_0000;
            mem_addr        <= 8'h00;
            sp              <= 2'b00;
            wdt_clear       <= 1'b0;
        end else begin
            wdt_clear <= 1'b0;
            case (state)
                ST_RUN: begin
                    if (issue) begin
                        work  <= next_work;
                        flags <= next_flags;
                        pc    <= next_pc;
                        if (pop)
                            sp <= sp - 2'd1;
                        if (set_gie)
                            irq_control_reg[`MRB_IRQ_GIE] <= 1'b1;
                        if (go_halt) begin
                            state     <= ST_HALT;
                            wdt_clear <= 1'b1;
                        end else if (two_cycle) begin
                            state <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    state <= ST_RUN;
                end
                ST_HALT: begin
                    if (dp_write & (dp_addr == `MRB_OFS_STATE) & hwdata[`MRB_STATE_WAKE]) begin
                        state <= ST_RUN;
                    end
                end
                default: begin
                    state <= ST_RUN;
                end
            endcase
            // Software writes; never collide with execution in the same cycle
            if (dp_write) begin
                case (dp_addr)
                    `MRB_OFS_OPND:    opnd  <= hwdata;
                    `MRB_OFS_WORK:    work  <= hwdata[7:0];
                    `MRB_OFS_STATUS:  flags <= hwdata[6:0];
                    `MRB_OFS_IRQCTL:  irq_control_reg <= hwdata[7:0];
                    `MRB_OFS_PC:      pc    <= hwdata[PC_W-1:0];
                    `MRB_OFS_STACK:   sp    <= sp + 2'd1;
                    `MRB_OFS_MEMADDR: mem_addr <= hwdata[7:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // Storage arrays carry no reset
    always @(posedge hclk) begin
        if (issue & mem_we)
            dmem[m_addr] <= next_mem;
        if (dp_write & (dp_addr == `MRB_OFS_MEMDATA))
            dmem[mem_addr] <= hwdata[7:0];
        if (dp_write & (dp_addr == `MRB_OFS_STACK))
            stack[sp] <= hwdata[PC_W-1:0];
    end

endmodule

`default_nettype wire

//--- verif/mrb_exec_monitor.sv
`include "mrb_consts.vh"
`default_nettype none
module mrb_exec_monitor (
    // Bus
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Core side
    input wire logic        sys_clk_run,
    input wire logic        global_irq_enable,
    input wire logic        wdt_clear
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       dp_wr;
    logic [7:0] dp_ofs;
    wire        take     = hsel && hready && htrans[1];
    wire        cmd      = dp_wr && dp_ofs == `MRB_OFS_CMD && sys_clk_run;
    wire        go_sleep = cmd && hwdata[4:0] == `MRB_OP_HALT;
    wire        irq_exit = cmd && hwdata[4:0] == `MRB_OP_INTERRUPT_EXIT;
    wire        wake     = dp_wr && dp_ofs == `MRB_OFS_STATE && hwdata[0];
    wire        gie_src  = irq_exit || (dp_wr && dp_ofs == `MRB_OFS_IRQCTL);
    // Writes have no wait state, so the data phase is the cycle after the take
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr <= 1'b0;
            dp_ofs <= 8'h00;
        end else if (hready) begin
            dp_wr <= take && hwrite;
            dp_ofs <= haddr[7:0];
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sleep_stop_a: assert property (go_sleep |-> ##[1:2] !sys_clk_run)
        else $error("clock still running after power-down");
    sleep_dog_a: assert property (go_sleep |-> ##[1:2] wdt_clear)
        else $error("no watchdog clear after power-down");
    dog_pulse_a: assert property (wdt_clear |=> !wdt_clear)
        else $error("watchdog clear longer than one cycle");
    dog_cause_a: assert property ($rose(wdt_clear) |-> $past(go_sleep) || $past(go_sleep, 2))
        else $error("watchdog clear without power-down");
    sleep_hold_a: assert property (!sys_clk_run && !wake && !$past(wake) |=> !sys_clk_run)
        else $error("clock restarted without wake");
    wake_run_a: assert property (wake && !sys_clk_run |-> ##[1:2] sys_clk_run)
        else $error("wake did not restart clock");
    exit_gie_a: assert property (irq_exit |-> ##[1:3] global_irq_enable)
        else $error("interrupt exit left global enable low");
    gie_cause_a: assert property ($changed(global_irq_enable) |->
        $past(gie_src) || $past(gie_src, 2) || $past(gie_src, 3))
        else $error("global enable changed without cause");
    rd_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    wr_nowait_a: assert property (take && hwrite |=> hreadyout && !hresp)
        else $error("write data phase not ready");
endmodule
bind mrb_exec mrb_exec_monitor mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .sys_clk_run(sys_clk_run),
    .global_irq_enable(global_irq_enable), .wdt_clear(wdt_clear));
`default_nettype wire

//--- verif/tb.sv
`include "mrb_consts.vh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b1;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'b010;
    logic [31:0] hwdata = 32'h0000_0000;
    wire         hready;
    wire         hresp;
    wire  [31:0] hrdata;
    wire         sys_clk_run;
    wire         global_irq_enable;
    wire         wdt_clear;
    int          error_cnt = 0;
    int          n_compared = 0;
    logic [7:0]  ew;
    logic [7:0]  em;
    logic [3:0]  ef;
    logic [11:0] epc = 12'h000;
    logic [4:0]  ops [21] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h09, 5'h0A,
        5'h0B, 5'h0C, 5'h0D, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17, 5'h18,
        5'h19, 5'h1A};
    logic [19:0] vec [3] = '{20'h9_A010, 20'h0_FFFF, 20'h8_0001};

    always #4 hclk = ~hclk;

    mrb_exec dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .sys_clk_run(sys_clk_run), .global_irq_enable(global_irq_enable),
        .wdt_clear(wdt_clear));

    task automatic give_verdict;
        if (error_cnt == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
        n_compared++;
        if (seen !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, seen);
        end
    endtask

    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        if (hready !== 1'b1) begin
            error_cnt++;
            give_verdict();
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        htrans <= 2'b10;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic wb(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rb(input string nm, input logic [7:0] a, input logic [11:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0000_0000, x);
        chk(nm, x, {20'h0_0000, e});
    endtask

    // Idle cycle after each command: a branch's second cycle drops a new one
    task automatic run(input logic [4:0] op);
        wb(`MRB_OFS_CMD, {27'h000_0000, op});
        @(posedge hclk);
        epc = epc + 12'h001;
    endtask

    task automatic model(input logic [4:0] op, input logic [7:0] imm);
        logic [8:0] s;
        logic [4:0] h;
        logic [4:0] g;
        logic       c;
        c = ef[0];
        s = {1'b0, ew} + {1'b0, ~em} + {8'h00, c};
        case (op)
            5'h01: ew = ~em;
            5'h02: begin
                h = {1'b0, ew[3:0]};
                if (h > 5'h09 || ef[1]) h = h + 5'h06;
                g = {1'b0, ew[7:4]} + {4'h0, h[4]};
                if (ew[7:4] > 4'h9 || c) g = g + 5'h06;
                if (ew[7:4] > 4'h9 || c) ef[0] = 1'b1;
                em = {g[3:0], h[3:0]};
            end
            5'h03: em = em - 8'h01;
            5'h04: ew = em - 8'h01;
            5'h05: em = em + 8'h01;
            5'h06: ew = em + 8'h01;
            5'h09: ew = imm;
            5'h0A: em = ew;
            5'h0B: ew = ew | em;
            5'h0C: ew = ew | imm;
            5'h0D: em = ew | em;
            5'h11: em = {em[6:0], em[7]};
            5'h12: ew = {em[6:0], em[7]};
            5'h13: {ef[0], em} = {em, c};
            5'h14: {ef[0], ew} = {em, c};
            5'h15: em = {em[0], em[7:1]};
            5'h16: ew = {em[0], em[7:1]};
            5'h17: {em, ef[0]} = {c, em};
            5'h18: {ew, ef[0]} = {c, em};
            default: begin
                h = {1'b0, ew[3:0]} + {1'b0, ~em[3:0]} + {4'h0, c};
                ef[1] = h[4];
                ef[0] = s[8];
                ef[3] = (ew[7] == ~em[7]) && (s[7] != ew[7]);
                if (op == 5'h19) ew = s[7:0];
                else em = s[7:0];
            end
        endcase
        if (op inside {5'h01, 5'h04, 5'h06, 5'h0B, 5'h0C, 5'h19}) ef[2] = ew == 8'h00;
        if (op inside {5'h03, 5'h05, 5'h0D, 5'h1A}) ef[2] = em == 8'h00;
    endtask

    initial begin
        repeat (100000) @(posedge hclk);
        error_cnt++;
        give_verdict();
    end

    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rb("work", `MRB_OFS_WORK, 12'h000);
        rb("flags", `MRB_OFS_STATUS, 12'h000);
        rb("pc", `MRB_OFS_PC, 12'h000);
        rb("irqctl", `MRB_OFS_IRQCTL, 12'h000);
        wb(`MRB_OFS_OPND, 32'h0ABC_C340);
        wb(`MRB_OFS_MEMADDR, 32'h0000_0040);
        foreach (vec[v]) begin
            foreach (ops[i]) begin
                {ew, em, ef} = vec[v];
                wb(`MRB_OFS_WORK, {24'h00_0000, ew});
                wb(`MRB_OFS_MEMDATA, {24'h00_0000, em});
                wb(`MRB_OFS_STATUS, {28'h000_0000, ef});
                run(ops[i]);
                model(ops[i], 8'hC3);
                rb("work", `MRB_OFS_WORK, {4'h0, ew});
                rb("mem", `MRB_OFS_MEMDATA, {4'h0, em});
                rb("flags", `MRB_OFS_STATUS, {8'h00, ef});
                rb("pc", `MRB_OFS_PC, epc);
            end
        end
        run(`MRB_OP_JMP);
        epc = 12'hABC;
        rb("pc", `MRB_OFS_PC, epc);
        wb(`MRB_OFS_STACK, 32'h0000_0123);
        wb(`MRB_OFS_STACK, 32'h0000_0456);
        run(`MRB_OP_RET);
        rb("pc", `MRB_OFS_PC, 12'h456);
        rb("sp", `MRB_OFS_STACK, 12'h001);
        run(`MRB_OP_RET_IMM);
        ew = 8'hC3;
        rb("pc", `MRB_OFS_PC, 12'h123);
        rb("work", `MRB_OFS_WORK, {4'h0, ew});
        wb(`MRB_OFS_STACK, 32'h0000_03FF);
        run(`MRB_OP_INTERRUPT_EXIT);
        epc = 12'h3FF;
        rb("pc", `MRB_OFS_PC, epc);
        rb("irqctl", `MRB_OFS_IRQCTL, 12'h001);
        chk("gie", 32'(global_irq_enable), 32'h0000_0001);
        rb("flags", `MRB_OFS_STATUS, {8'h00, ef});
        wb(`MRB_OFS_STATUS, {26'h000_0000, 2'b10, ef});
        run(`MRB_OP_HALT);
        repeat (2) @(posedge hclk);
        chk("run", 32'(sys_clk_run), 32'h0000_0000);
        rb("flags", `MRB_OFS_STATUS, {6'h00, 2'b01, ef});
        rb("pc", `MRB_OFS_PC, epc);
        rb("state", `MRB_OFS_STATE, 12'h003);
        wb(`MRB_OFS_CMD, {27'h000_0000, `MRB_OP_MOV_IMM});
        rb("work", `MRB_OFS_WORK, {4'h0, ew});
        rb("mem", `MRB_OFS_MEMDATA, {4'h0, em});
        wb(`MRB_OFS_STATE, 32'h0000_0001);
        repeat (2) @(posedge hclk);
        chk("run", 32'(sys_clk_run), 32'h0000_0001);
        rb("state", `MRB_OFS_STATE, 12'h000);
        run(5'h1F);
        rb("pc", `MRB_OFS_PC, epc);
        rb("flags", `MRB_OFS_STATUS, {6'h00, 2'b01, ef});
        wb(8'h3C, 32'h0000_00FF);
        rb("hole", 8'h3C, 12'h000);
        give_verdict();
    end
endmodule
`default_nettype wire
